/* logic/fodl_defines.svh */
// fodl constants: register map, field positions, reset values, timing counts
`ifndef FODL_DEFINES_SVH
`define FODL_DEFINES_SVH
`define FODL_ADDR_LINK_CTRL 8'h12
`define FODL_ADDR_TX_MSG    8'h13
`define FODL_ADDR_RX_MSG    8'h15
`define FODL_ADDR_SPARE_SEL 8'h17
`define FODL_ADDR_IMASK3    8'h1e
`define FODL_BIT_EXT        7
`define FODL_BIT_MSG        6
`define FODL_BIT_CTLA       5
`define FODL_BIT_IMASK_MSG  1
`define FODL_REG_RESET      8'h00
`define FODL_CLK_NS         20
`define FODL_CLK_KHZ        50000
`define FODL_PULSE_NS       244
`define FODL_PULSE_CYC      (`FODL_PULSE_NS / `FODL_CLK_NS)
`define FODL_SECOND_MS      1000
`define FODL_PAUSE_MS       100
`define FODL_MSG_NEED       7
`define FODL_MSG_WINDOW     10
`define FODL_FLAG_ONES      8
`endif

/* logic/fodl_pkg.sv */
// fodl types shared by the link block and its bench
package fodl_pkg;
	// framer timing and receive stream, same clock domain
	typedef struct packed {
		logic       e1_mode;
		logic       slc_mode;
		logic       tx_sa_slot;
		logic [2:0] tx_sa_idx;
		logic       tx_fs_slot;
		logic       tx_fdl_slot;
		logic       rx_sa_slot;
		logic [2:0] rx_sa_idx;
		logic       rx_fs_slot;
		logic       rx_fdl_slot;
		logic       rx_line_bit;
	} fodl_frm_t;
	// overhead insertion back to the framer
	typedef struct packed {
		logic force_ones;
		logic use_bit;
		logic bit_val;
	} fodl_ins_t;
	typedef enum logic [1:0] {MSG_HUNT, MSG_BYTE, MSG_SCAN, MSG_DECIDE} fodl_msg_st_t;
endpackage

/* logic/fodl_pulse.sv */
// fodl link clock pulse generator with a data sampling tap
`timescale 1ns/1ps
`default_nettype none
module fodl_pulse #(
	parameter int unsigned WIDTH = 12
) (
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic rst,
	// trigger and outputs
	input  wire logic start,
	output logic      pulse_r,
	output logic      tap_r
);
	localparam int unsigned CW = $clog2(WIDTH + 1);
	logic [CW-1:0] cnt_r;
	logic [CW-1:0] cnt_nxt;

	// remaining cycles of the pulse
	always_comb begin
		if (start) begin
			cnt_nxt = CW'(WIDTH);
		end else if (cnt_r != '0) begin
			cnt_nxt = cnt_r - 1'b1;
		end else begin
			cnt_nxt = '0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cnt_r   <= '0;
			pulse_r <= 1'b0;
			tap_r   <= 1'b0;
		end else begin
			cnt_r   <= cnt_nxt;
			pulse_r <= (cnt_nxt != '0);
			tap_r   <= (cnt_r == CW'(WIDTH - 2)); // pin data has crossed the synchroniser
		end
	end

	sequence s_high6;
		pulse_r [*6];
	endsequence
	property p_pulse_width;
		@(posedge ref_clk) disable iff (rst)
		$rose(pulse_r) |-> s_high6 ##(WIDTH - 5) !pulse_r;
	endproperty
	a_pulse_width: assert property (p_pulse_width) else $error("link clock pulse width wrong");
	property p_tap_in_pulse;
		@(posedge ref_clk) disable iff (rst)
		$rose(pulse_r) |-> ##3 tap_r && pulse_r;
	endproperty
	a_tap_in_pulse: assert property (p_tap_in_pulse) else $error("sample tap misplaced");
endmodule
`default_nettype wire

/* logic/fodl_hist_mem.sv */
// fodl received message history memory, registered read
`timescale 1ns/1ps
`default_nettype none
module fodl_hist_mem #(
	parameter int unsigned DEPTH = 10,
	parameter int unsigned AW    = 4
) (
	// clock
	input  wire logic          ref_clk,
	// write side
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_addr,
	input  wire logic [7:0]    wr_data,
	// read side
	input  wire logic [AW-1:0] rd_addr,
	output logic      [7:0]    rd_data_r
);
	logic [7:0] mem_r [DEPTH];

	// contents need no reset; the fill count says which entries are live
	always_ff @(posedge ref_clk) begin
		if (wr_en) begin
			mem_r[wr_addr] <= wr_data;
		end
		rd_data_r <= mem_r[rd_addr];
	end
endmodule
`default_nettype wire

/* logic/fodl_link.sv */
// fodl overhead data link steering: E1 spare bits, T1 overhead, bit messages
`timescale 1ns/1ps
`default_nettype none
`include "fodl_defines.svh"
module fodl_link import fodl_pkg::*; #(
	parameter int unsigned SEC_CYC   = `FODL_SECOND_MS * `FODL_CLK_KHZ,
	parameter int unsigned PAUSE_CYC = `FODL_PAUSE_MS * `FODL_CLK_KHZ
) (
	// clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst,
	// register port
	input  wire logic       cpu_cs,
	input  wire logic       cpu_we,
	input  wire logic [7:0] cpu_addr,
	input  wire logic [7:0] cpu_wdata,
	output logic      [7:0] cpu_rdata_r,
	// framer side
	input  wire fodl_frm_t  frm,
	output fodl_ins_t       ins_r,
	// link pins
	input  wire logic       force_all_ones_n,
	input  wire logic       tx_link_data,
	output logic            tx_link_clock,
	output logic            rx_link_data_r,
	output logic            rx_link_clock,
	output logic            irq_out_r,
	output logic            irq_oe_r,
	// controller a
	input  wire logic       ctl_tx_bit,
	input  wire logic       ctl_tx_want,
	input  wire logic       ctl_irq,
	output logic            ctl_tx_strobe_r,
	output logic            ctl_rx_strobe_r,
	output logic            ctl_rx_bit_r
);
	localparam int unsigned SW = $clog2(SEC_CYC + 1);
	localparam int unsigned PW = $clog2(PAUSE_CYC + 1);
	logic [7:0] link_ctrl_r, tx_msg_r, rx_msg_r, imask3_r;
	logic [4:0] spare_sel_r;
	logic [1:0] aon_sync_r, txd_sync_r;
	logic       link_bit_r, tx_tap, rx_tap_unused, msg_flag_r;
	logic       pause_r, tx_start, rx_start, tx_t1_slot, rx_t1_slot;
	logic       tx_e1_hit, rx_e1_hit, ctla_on, bom_on;
	logic [3:0] pat_r;
	logic [15:0] pat_word;
	logic [SW-1:0] since_r;
	logic [PW-1:0] pcnt_r;
	fodl_msg_st_t st_r;
	logic [3:0] ones_r, bcnt_r, wptr_r, fill_r, sidx_r, hits_r, hits_tot;
	logic [7:0] byte_r, hist_rd;
	logic       look_r, hist_we;

	// one spare-bit select decode serves transmit and receive
	function automatic logic sel_hit(input logic [4:0] sel, input logic [2:0] idx);
		sel_hit = (idx < 3'd5) ? sel[idx] : 1'b0;
	endfunction

	// pins from outside the clock domain, two flops before use
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			aon_sync_r <= 2'b00;
			txd_sync_r <= 2'b00;
		end else begin
			aon_sync_r <= {aon_sync_r[0], force_all_ones_n};
			txd_sync_r <= {txd_sync_r[0], tx_link_data};
		end
	end

	// slot decode; fs slot for SLC-96, facility bits for ESF
	assign tx_t1_slot = !frm.e1_mode && (frm.slc_mode ? frm.tx_fs_slot : frm.tx_fdl_slot);
	assign rx_t1_slot = !frm.e1_mode && (frm.slc_mode ? frm.rx_fs_slot : frm.rx_fdl_slot);
	assign tx_e1_hit = frm.e1_mode && frm.tx_sa_slot && sel_hit(spare_sel_r, frm.tx_sa_idx);
	assign rx_e1_hit = frm.e1_mode && frm.rx_sa_slot && sel_hit(spare_sel_r, frm.rx_sa_idx);
	assign ctla_on = link_ctrl_r[`FODL_BIT_CTLA] && (frm.e1_mode || !frm.slc_mode);
	assign bom_on = !frm.e1_mode && link_ctrl_r[`FODL_BIT_MSG] && !pause_r;
	// pins clock a bit in only where they own the slot
	assign tx_start = (tx_e1_hit && !ctla_on)
		|| (tx_t1_slot && !bom_on && link_ctrl_r[`FODL_BIT_EXT]);
	assign rx_start = (rx_e1_hit && !ctla_on)
		|| (rx_t1_slot && link_ctrl_r[`FODL_BIT_EXT]);
	assign pat_word = {8'hff, 1'b0, tx_msg_r[6:1], 1'b0};

	fodl_pulse #(.WIDTH(`FODL_PULSE_CYC)) u_tx_pulse (
		.ref_clk (ref_clk),
		.rst     (rst),
		.start   (tx_start),
		.pulse_r (tx_link_clock),
		.tap_r   (tx_tap)
	);
	fodl_pulse #(.WIDTH(`FODL_PULSE_CYC)) u_rx_pulse (
		.ref_clk (ref_clk),
		.rst     (rst),
		.start   (rx_start),
		.pulse_r (rx_link_clock),
		.tap_r   (rx_tap_unused)
	);

	// register writes; all control state clears on reset
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			link_ctrl_r <= `FODL_REG_RESET;
			tx_msg_r    <= `FODL_REG_RESET;
			spare_sel_r <= 5'h00;
			imask3_r    <= `FODL_REG_RESET;
		end else if (cpu_cs && cpu_we) begin
			unique case (cpu_addr)
				`FODL_ADDR_LINK_CTRL: link_ctrl_r <= cpu_wdata;
				`FODL_ADDR_TX_MSG:    tx_msg_r <= cpu_wdata;
				`FODL_ADDR_SPARE_SEL: spare_sel_r <= cpu_wdata[4:0];
				`FODL_ADDR_IMASK3:    imask3_r <= cpu_wdata;
				default:              ;
			endcase
		end
	end

	// register reads; unmapped offsets read zero
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cpu_rdata_r <= 8'h00;
		end else if (cpu_cs && !cpu_we) begin
			unique case (cpu_addr)
				`FODL_ADDR_LINK_CTRL: cpu_rdata_r <= link_ctrl_r;
				`FODL_ADDR_TX_MSG:    cpu_rdata_r <= tx_msg_r;
				`FODL_ADDR_RX_MSG:    cpu_rdata_r <= rx_msg_r;
				`FODL_ADDR_SPARE_SEL: cpu_rdata_r <= {3'h0, spare_sel_r};
				`FODL_ADDR_IMASK3:    cpu_rdata_r <= imask3_r;
				default:              cpu_rdata_r <= 8'h00;
			endcase
		end
	end

	// pin data taken inside the pulse, just after the rising edge
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			link_bit_r <= 1'b0;
		end else if (tx_tap) begin
			link_bit_r <= txd_sync_r[1];
		end
	end

	// message pause: one window of controller traffic per second
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pause_r <= 1'b0;
			since_r <= '0;
			pcnt_r  <= '0;
		end else if (pause_r) begin
			pcnt_r <= pcnt_r + 1'b1;
			if (pcnt_r == PW'(PAUSE_CYC - 1) || !ctl_tx_want) begin
				pause_r <= 1'b0;
			end
		end else begin
			if (since_r != SW'(SEC_CYC)) begin
				since_r <= since_r + 1'b1;
			end
			if (link_ctrl_r[`FODL_BIT_MSG] && ctla_on && ctl_tx_want
				&& since_r == SW'(SEC_CYC)) begin
				pause_r <= 1'b1;
				since_r <= '0;
				pcnt_r  <= '0;
			end
		end
	end

	// message pattern position, advances once per overhead slot
	always_ff @(posedge ref_clk) begin
		if (rst || !bom_on) begin
			pat_r <= 4'h0;
		end else if (tx_t1_slot) begin
			pat_r <= pat_r + 1'b1;
		end
	end

	// insertion: messages first, then pins, then controller a
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ins_r <= '0;
			ctl_tx_strobe_r <= 1'b0;
		end else begin
			ins_r.force_ones <= !aon_sync_r[1];
			ctl_tx_strobe_r  <= 1'b0;
			ins_r.use_bit    <= 1'b0;
			ins_r.bit_val    <= 1'b0;
			if (tx_t1_slot && bom_on) begin
				ins_r.use_bit <= 1'b1;
				ins_r.bit_val <= pat_word[4'd15 - pat_r];
			end else if (tx_start) begin
				ins_r.use_bit <= 1'b1;
				ins_r.bit_val <= link_bit_r;
			end else if ((tx_t1_slot || tx_e1_hit) && ctla_on) begin
				ins_r.use_bit   <= 1'b1;
				ins_r.bit_val   <= ctl_tx_bit;
				ctl_tx_strobe_r <= 1'b1;
			end
		end
	end

	// receive pins and controller feed; taken before the elastic store so
	// a frame slip there never touches link bits
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rx_link_data_r  <= 1'b0;
			ctl_rx_strobe_r <= 1'b0;
			ctl_rx_bit_r    <= 1'b0;
		end else begin
			if (frm.e1_mode || rx_t1_slot) begin
				rx_link_data_r <= frm.rx_line_bit;
			end
			ctl_rx_strobe_r <= ctla_on && (rx_e1_hit || rx_t1_slot);
			if (ctla_on && (rx_e1_hit || rx_t1_slot)) begin
				ctl_rx_bit_r <= frm.rx_line_bit;
			end
		end
	end

	fodl_hist_mem #(.DEPTH(`FODL_MSG_WINDOW), .AW(4)) u_hist (
		.ref_clk   (ref_clk),
		.wr_en     (hist_we),
		.wr_addr   (wptr_r),
		.wr_data   ({byte_r[6:0], frm.rx_line_bit}),
		.rd_addr   (sidx_r),
		.rd_data_r (hist_rd)
	);
	assign hist_we = (st_r == MSG_BYTE) && rx_t1_slot && bcnt_r == 4'd7 && !frm.rx_line_bit;
	assign hits_tot = hits_r + 4'((look_r && hist_rd == byte_r) ? 1 : 0);

	// message receiver: flag hunt, byte collect, history scan, decision
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			st_r <= MSG_HUNT;
			ones_r <= 4'h0;
			bcnt_r <= 4'h0;
			byte_r <= 8'h00;
			wptr_r <= 4'h0;
			fill_r <= 4'h0;
			sidx_r <= 4'h0;
			hits_r <= 4'h0;
			look_r <= 1'b0;
		end else begin
			unique case (st_r)
				MSG_HUNT: if (rx_t1_slot) begin
					if (frm.rx_line_bit) begin
						ones_r <= (ones_r == 4'(`FODL_FLAG_ONES)) ? ones_r : ones_r + 1'b1;
					end else begin
						ones_r <= 4'h0;
						if (ones_r == 4'(`FODL_FLAG_ONES)) begin
							st_r   <= MSG_BYTE;
							byte_r <= 8'h00;
							bcnt_r <= 4'h1;
						end
					end
				end
				MSG_BYTE: if (rx_t1_slot) begin
					byte_r <= {byte_r[6:0], frm.rx_line_bit};
					bcnt_r <= bcnt_r + 1'b1;
					if (bcnt_r == 4'd7) begin
						st_r   <= frm.rx_line_bit ? MSG_HUNT : MSG_SCAN;
						sidx_r <= 4'h0;
						hits_r <= 4'h0;
						look_r <= 1'b0;
					end
				end
				MSG_SCAN: begin
					if (sidx_r == 4'h0) begin
						wptr_r <= (wptr_r == 4'(`FODL_MSG_WINDOW - 1)) ? 4'h0 : wptr_r + 1'b1;
						fill_r <= (fill_r == 4'(`FODL_MSG_WINDOW)) ? fill_r : fill_r + 1'b1;
					end
					look_r <= sidx_r < fill_r || sidx_r == 4'h0;
					hits_r <= hits_tot;
					sidx_r <= sidx_r + 1'b1;
					if (sidx_r == 4'(`FODL_MSG_WINDOW - 1)) begin
						st_r <= MSG_DECIDE;
					end
				end
				MSG_DECIDE: begin
					hits_r <= hits_tot;
					st_r   <= MSG_HUNT;
				end
			endcase
		end
	end

	// latest persistent message and its sticky event; a new message in the
	// read cycle wins over the clear
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rx_msg_r   <= `FODL_REG_RESET;
			msg_flag_r <= 1'b0;
		end else if (st_r == MSG_DECIDE && hits_tot >= 4'(`FODL_MSG_NEED)
			&& byte_r != rx_msg_r) begin
			rx_msg_r   <= byte_r;
			msg_flag_r <= 1'b1;
		end else if (cpu_cs && !cpu_we && cpu_addr == `FODL_ADDR_RX_MSG) begin
			msg_flag_r <= 1'b0;
		end
	end

	// open-drain request: pulls low only; floats while all-ones pin is low
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			irq_out_r <= 1'b0;
			irq_oe_r  <= 1'b0;
		end else begin
			irq_out_r <= 1'b0;
			irq_oe_r  <= aon_sync_r[1] && ((msg_flag_r && imask3_r[`FODL_BIT_IMASK_MSG])
				|| (ctl_irq && ctla_on));
		end
	end

	property p_all_ones;
		@(posedge ref_clk) disable iff (rst)
		!aon_sync_r[1] |=> ins_r.force_ones && !irq_oe_r;
	endproperty
	a_all_ones: assert property (p_all_ones) else $error("all-ones or float missing");
	property p_clock_cause;
		@(posedge ref_clk) disable iff (rst)
		$rose(tx_link_clock) |-> $past(tx_start) && ($past(frm.e1_mode) || $past(tx_t1_slot));
	endproperty
	a_clock_cause: assert property (p_clock_cause) else $error("tx clock outside slot");
	property p_override;
		@(posedge ref_clk) disable iff (rst)
		tx_e1_hit && !ctla_on |=> ins_r.use_bit && ins_r.bit_val == $past(link_bit_r);
	endproperty
	a_override: assert property (p_override) else $error("spare bit not overridden");
	property p_unselected;
		@(posedge ref_clk) disable iff (rst)
		frm.e1_mode && frm.tx_sa_slot && !sel_hit(spare_sel_r, frm.tx_sa_idx) |=> !ins_r.use_bit;
	endproperty
	a_unselected: assert property (p_unselected) else $error("unselected spare bit used");
	property p_pattern;
		@(posedge ref_clk) disable iff (rst)
		tx_t1_slot && bom_on && pat_r < 4'd8 |=> ins_r.use_bit && ins_r.bit_val;
	endproperty
	a_pattern: assert property (p_pattern) else $error("message flag bit not one");
	sequence s_decide_hit;
		st_r == MSG_DECIDE && hits_tot >= 4'(`FODL_MSG_NEED) && byte_r != rx_msg_r;
	endsequence
	property p_msg_load;
		@(posedge ref_clk) disable iff (rst)
		s_decide_hit |=> rx_msg_r == $past(byte_r) && msg_flag_r;
	endproperty
	a_msg_load: assert property (p_msg_load) else $error("message not loaded");
	property p_msg_hold;
		@(posedge ref_clk) disable iff (rst)
		st_r != MSG_DECIDE |=> $stable(rx_msg_r);
	endproperty
	a_msg_hold: assert property (p_msg_hold) else $error("message changed without check");
	property p_msg_irq;
		@(posedge ref_clk) disable iff (rst)
		msg_flag_r && imask3_r[`FODL_BIT_IMASK_MSG] && aon_sync_r[1] |=> irq_oe_r;
	endproperty
	a_msg_irq: assert property (p_msg_irq) else $error("message interrupt missing");
	property p_ctl_masked;
		@(posedge ref_clk) disable iff (rst)
		!ctla_on && !(msg_flag_r && imask3_r[`FODL_BIT_IMASK_MSG]) |=> !irq_oe_r;
	endproperty
	a_ctl_masked: assert property (p_ctl_masked) else $error("detached controller interrupt");
	// counter bound: the real pause length is far beyond any delay range
	property p_pause_len;
		@(posedge ref_clk) disable iff (rst)
		pause_r |-> pcnt_r < PW'(PAUSE_CYC);
	endproperty
	a_pause_len: assert property (p_pause_len) else $error("message pause too long");
	property p_pause_gap;
		@(posedge ref_clk) disable iff (rst)
		$rose(pause_r) |-> $past(since_r) == SW'(SEC_CYC);
	endproperty
	a_pause_gap: assert property (p_pause_gap) else $error("message pause too early");
	property p_reset_zero;
		@(posedge ref_clk) rst |=> link_ctrl_r == 8'h00 && spare_sel_r == 5'h00
			&& tx_msg_r == 8'h00 && rx_msg_r == 8'h00 && imask3_r == 8'h00;
	endproperty
	a_reset_zero: assert property (p_reset_zero) else $error("register not cleared");
endmodule
`default_nettype wire

/* bench/fodl_far_ctl.sv */
// fodl far-side serial link controller model
`timescale 1ns/1ps
`default_nettype none
module fodl_far_ctl (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst,
	// link pins
	input  wire logic        tx_link_clock,
	input  wire logic        rx_link_clock,
	input  wire logic        rx_link_data_r,
	output logic             tx_link_data,
	// bench side
	input  wire logic [15:0] tx_word,
	output logic      [15:0] rx_word_r
);
	logic [3:0] tx_pos_r;
	logic       txc_d_r;
	logic       rxc_d_r;
	// next bit moves out after the clock falls, so it is steady across the next rise
	always_ff @(posedge ref_clk) begin
		txc_d_r <= tx_link_clock;
		if (rst)
			tx_pos_r <= 4'h0;
		else if (txc_d_r && !tx_link_clock)
			tx_pos_r <= tx_pos_r + 4'h1;
	end
	assign tx_link_data = tx_word[tx_pos_r];
	// receive bit taken on the clock rise, shifted in at the low end
	always_ff @(posedge ref_clk) begin
		rxc_d_r <= rx_link_clock;
		if (rst)
			rx_word_r <= 16'h0000;
		else if (rx_link_clock && !rxc_d_r)
			rx_word_r <= {rx_word_r[14:0], rx_link_data_r};
	end
endmodule
`default_nettype wire

/* bench/tb_framer_overhead_data_link.sv */
// fodl link block bench: register, E1 spare bit, T1 overhead and message tests
`timescale 1ns/1ps
`default_nettype none
`include "fodl_defines.svh"
module tb_framer_overhead_data_link import fodl_pkg::*;;
	localparam logic [15:0] PAT = 16'h0016;
	localparam logic [7:0]  REGS [5] = '{`FODL_ADDR_LINK_CTRL, `FODL_ADDR_TX_MSG,
		`FODL_ADDR_RX_MSG, `FODL_ADDR_SPARE_SEL, `FODL_ADDR_IMASK3};
	logic        ref_clk = 1'b0;
	logic        rst = 1'b1;
	logic        cpu_cs = 1'b0;
	logic        cpu_we = 1'b0;
	logic [7:0]  cpu_addr = 8'h00;
	logic [7:0]  cpu_wdata = 8'h00;
	logic [7:0]  cpu_rdata_r;
	fodl_frm_t   frm = '0;
	fodl_ins_t   ins_r;
	logic        ones_n = 1'b1;
	logic        tx_link_data;
	logic        tx_link_clock;
	logic        rx_link_data_r;
	logic        rx_link_clock;
	logic        irq_out_r;
	logic        irq_oe_r;
	logic        ctl_irq = 1'b0;
	logic        ctl_tx_bit = 1'b0;
	int          ts = 0;
	int          rs = 0;
	int          n_ts;
	int          n_rs;
	logic        ctl_tx_want = 1'b0;
	logic        ctl_tx_strobe_r;
	logic        ctl_rx_strobe_r;
	logic        ctl_rx_bit_r;
	logic [15:0] rx_word_r;
	logic [15:0] got;
	logic        bv;
	int          miscompares = 0;
	int          check_count = 0;
	bit          hit;
	// 50 MHz clock
	always #10 ref_clk = ~ref_clk;
	fodl_link #(.SEC_CYC(200), .PAUSE_CYC(40)) i_fodl_link (
		.ref_clk(ref_clk), .rst(rst), .cpu_cs(cpu_cs), .cpu_we(cpu_we),
		.cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_rdata_r(cpu_rdata_r),
		.frm(frm), .ins_r(ins_r), .force_all_ones_n(ones_n), .tx_link_data(tx_link_data),
		.tx_link_clock(tx_link_clock), .rx_link_data_r(rx_link_data_r),
		.rx_link_clock(rx_link_clock), .irq_out_r(irq_out_r), .irq_oe_r(irq_oe_r),
		.ctl_tx_bit(ctl_tx_bit), .ctl_tx_want(ctl_tx_want), .ctl_irq(ctl_irq),
		.ctl_tx_strobe_r(ctl_tx_strobe_r), .ctl_rx_strobe_r(ctl_rx_strobe_r),
		.ctl_rx_bit_r(ctl_rx_bit_r));
	fodl_far_ctl i_fodl_far_ctl (
		.ref_clk(ref_clk), .rst(rst), .tx_link_clock(tx_link_clock),
		.rx_link_clock(rx_link_clock), .rx_link_data_r(rx_link_data_r),
		.tx_link_data(tx_link_data), .tx_word(PAT), .rx_word_r(rx_word_r));
	// controller a strobes, counted once each while they stand
	always @(negedge ref_clk) begin
		ts += ctl_tx_strobe_r;
		rs += ctl_rx_strobe_r;
	end
	// shared comparison, counts every check
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// one register access per cycle with cs high; read data lands the cycle after
	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		{cpu_cs, cpu_we, cpu_addr, cpu_wdata} = {2'b11, a, d};
		@(negedge ref_clk);
		cpu_cs = 1'b0;
	endtask
	task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge ref_clk);
		{cpu_cs, cpu_we, cpu_addr} = {2'b10, a};
		@(negedge ref_clk);
		cpu_cs = 1'b0;
		chk("register read", {8'h00, e}, {8'h00, cpu_rdata_r});
	endtask
	// one overhead slot (kind 0 spare bit, 1 signaling framing, 2 facility link);
	// a negative expectation skips that check; slots stay 15 cycles apart
	task automatic slot(input int kind, input logic [2:0] idx, input logic lb,
			input int ue, input int ev, input int tce, input int rce);
		int tc;
		int rc;
		tc = 0;
		rc = 0;
		@(negedge ref_clk);
		frm.rx_line_bit = lb;
		frm.tx_sa_idx = idx;
		frm.rx_sa_idx = idx;
		{frm.tx_sa_slot, frm.rx_sa_slot} = {2{kind == 0}};
		{frm.tx_fs_slot, frm.rx_fs_slot} = {2{kind == 1}};
		{frm.tx_fdl_slot, frm.rx_fdl_slot} = {2{kind == 2}};
		@(negedge ref_clk);
		// insertion stands only in the cycle after the slot edge
		bv = ins_r.bit_val;
		if (ue >= 0) chk("insert strobe", 16'(ue), {15'h0, ins_r.use_bit});
		if (ev >= 0) chk("insert value", 16'(ev), {15'h0, bv});
		chk("receive link data", {15'h0, lb}, {15'h0, rx_link_data_r});
		{frm.tx_sa_slot, frm.rx_sa_slot, frm.tx_fs_slot} = 3'b000;
		{frm.rx_fs_slot, frm.tx_fdl_slot, frm.rx_fdl_slot} = 3'b000;
		for (int i = 0; i < 13; i++) begin
			tc += tx_link_clock;
			rc += rx_link_clock;
			@(negedge ref_clk);
		end
		if (tce >= 0) chk("tx clock cycles", 16'(tce), 16'(tc));
		if (rce >= 0) chk("rx clock cycles", 16'(rce), 16'(rc));
	endtask
	// watchdog against a hung run
	initial begin
		#1ms;
		miscompares++;
		print_verdict();
	end
	initial begin
		repeat (2) @(negedge ref_clk);
		rst = 1'b0;
		// reset values and register access kinds
		foreach (REGS[k]) reg_rd(REGS[k], 8'h00);
		reg_wr(`FODL_ADDR_SPARE_SEL, 8'hf5);
		reg_rd(`FODL_ADDR_SPARE_SEL, 8'h15);
		reg_wr(`FODL_ADDR_RX_MSG, 8'h77);
		reg_rd(`FODL_ADDR_RX_MSG, 8'h00);
		reg_wr(8'h40, 8'h55);
		reg_rd(8'h40, 8'h00);
		// E1: spare bits 0, 2 and 4 selected, link data overrides the slot
		frm.e1_mode = 1'b1;
		slot(0, 3'd0, 1'b1, 1, -1, 12, 12);
		slot(0, 3'd1, 1'b0, 0, -1, 0, 0);
		slot(0, 3'd2, 1'b0, 1, PAT[0], 12, 12);
		slot(0, 3'd3, 1'b1, 0, -1, 0, 0);
		slot(0, 3'd4, 1'b1, 1, PAT[1], 12, 12);
		chk("far side receive bits", 16'h0005, rx_word_r);
		// T1 external pins: ESF uses facility link slots, SLC-96 the framing bit
		frm.e1_mode = 1'b0;
		slot(2, 3'd0, 1'b0, 0, -1, 0, 0);
		reg_wr(`FODL_ADDR_LINK_CTRL, 8'h80);
		slot(2, 3'd0, 1'b1, 1, PAT[2], 12, 12);
		frm.slc_mode = 1'b1;
		slot(1, 3'd0, 1'b0, 1, PAT[3], 12, 12);
		slot(2, 3'd0, 1'b0, 0, -1, 0, 0);
		frm.slc_mode = 1'b0;
		// repeating bit message 8 ones then 0 msg[6:1] 0
		reg_wr(`FODL_ADDR_TX_MSG, 8'h5a);
		reg_wr(`FODL_ADDR_LINK_CTRL, 8'h40);
		for (int i = 0; i < 16; i++) begin
			slot(2, 3'd0, 1'b0, 1, -1, -1, -1);
			got = {got[14:0], bv};
		end
		hit = 0;
		for (int r = 0; r < 16; r++) hit |= (({got, got} >> r) & 16'hffff) == 16'hff5a;
		chk("message pattern found", 16'h1, {15'h0, hit});
		// received message needs 7 copies behind an eight-ones flag
		reg_wr(`FODL_ADDR_IMASK3, 8'h02);
		for (int n = 0; n < 7; n++) begin
			for (int b = 15; b >= 0; b--) slot(2, 3'd0, logic'(16'hff3c >> b), -1, -1, -1, -1);
			if (n == 5) chk("irq before persistence", 16'h0, {15'h0, irq_oe_r});
		end
		repeat (20) @(negedge ref_clk);
		chk("message irq", 16'h1, {15'h0, irq_oe_r});
		chk("irq level", 16'h0, {15'h0, irq_out_r});
		ones_n = 1'b0;
		repeat (5) @(negedge ref_clk);
		chk("all ones forced", 16'h1, {15'h0, ins_r.force_ones});
		chk("irq floated", 16'h0, {15'h0, irq_oe_r});
		ones_n = 1'b1;
		repeat (5) @(negedge ref_clk);
		chk("irq back", 16'h1, {15'h0, irq_oe_r});
		chk("all ones released", 16'h0, {15'h0, ins_r.force_ones});
		reg_rd(`FODL_ADDR_RX_MSG, 8'h3c);
		repeat (2) @(negedge ref_clk);
		chk("irq cleared by read", 16'h0, {15'h0, irq_oe_r});
		// controller a interrupt passes only while attached
		ctl_irq = 1'b1;
		repeat (3) @(negedge ref_clk);
		chk("detached controller irq", 16'h0, {15'h0, irq_oe_r});
		reg_wr(`FODL_ADDR_LINK_CTRL, 8'h20);
		repeat (3) @(negedge ref_clk);
		chk("attached controller irq", 16'h1, {15'h0, irq_oe_r});
		// controller a feeds slots; a message pause hands it the slot, then the pattern resumes
		ctl_tx_want = 1'b1;
		n_ts = ts;
		n_rs = rs;
		slot(2, 3'd0, 1'b1, 1, 0, 0, 0);
		chk("controller rx bit", 16'h1, {15'h0, ctl_rx_bit_r});
		reg_wr(`FODL_ADDR_LINK_CTRL, 8'h60);
		slot(2, 3'd0, 1'b0, 1, 0, 0, 0);
		repeat (30) @(negedge ref_clk);
		slot(2, 3'd0, 1'b0, 1, 1, 0, 0);
		chk("controller tx strobes", 16'h2, 16'(ts - n_ts));
		chk("controller rx strobes", 16'h3, 16'(rs - n_rs));
		chk("controller rx bit", 16'h0, {15'h0, ctl_rx_bit_r});
		frm.e1_mode = 1'b1;
		reg_wr(`FODL_ADDR_LINK_CTRL, 8'h00);
		repeat (3) @(negedge ref_clk);
		chk("E1 detached controller irq", 16'h0, {15'h0, irq_oe_r});
		print_verdict();
	end
endmodule
`default_nettype wire
